// file: logic/onoff_control_setpoint_select.sv
`timescale 1ns/1ns
`include "onoff_params.svh"
// Behaviour
// - Each output picks PID or on/off independently from its type setting.
// - PID mode: proportional, integral and derivative terms feed output power.
// - On/off outputs are only fully off or fully on.
// - No deadband: heating off at setpoint plus half hysteresis, on at minus half.
// - Each output has its own hysteresis applied only to itself.
// - Heating and cooling deadbands are separate and shift setpoint and window.
// - Positive deadband lowers heating and raises cooling effective setpoint.
// - Heating: on at sp-db-h/2, off at sp-db+h/2.
// - Cooling: on at sp+db+h/2, off at sp+db-h/2.
// - A running ramp or recipe overrides every other setpoint source.
// - Otherwise an enabled remote analog input gives the setpoint.
// - Otherwise second setpoint if enabled, else local or host setpoint.
// - Recipe engine runs a single ramp or up to eight ramp/soak steps.
// - Soak levels, host and second setpoints are clamped to limits.
// - Host writes RAM, non-volatile copy or both; control uses RAM.
// - At power-up the stored setpoint is copied into RAM first.
// - Second setpoint is selected only by contact; value is editable.
// - Remote setpoint enabled only while its contact is closed; scaled.
module onoff_control_setpoint_select
    import onoff_pkg::*;
#(
    parameter int PV_W  = `PV_W,
    parameter int RAW_W = `RAS_RAW_W,
    parameter int STEPS = `RECIPE_STEPS
)
(
    // Clock, reset, enable.
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    input  wire logic                 i_ce,
    // Process value sample.
    input  wire logic signed [15:0]   i_pv,
    input  wire logic                 i_pv_valid,
    // Output configuration and PID gains.
    input  wire out_cfg_t             i_cfg1,
    input  wire out_cfg_t             i_cfg2,
    input  wire logic        [7:0]    i_kp,
    input  wire logic        [7:0]    i_ki,
    input  wire logic        [7:0]    i_kd,
    // Setpoint limits and remote scaling.
    input  wire logic signed [15:0]   i_sp_lo,
    input  wire logic signed [15:0]   i_sp_hi,
    input  wire logic signed [15:0]   i_ras_lo,
    input  wire logic signed [15:0]   i_ras_hi,
    input  wire logic        [11:0]   i_ras_raw,
    input  wire logic                 i_ras_contact,
    input  wire logic                 i_sp2_contact,
    // Setpoint writes from panel or host.
    input  wire sp_write_t            i_sp_wr,
    input  wire logic                 i_sp2_wr,
    input  wire logic signed [15:0]   i_sp2_val,
    input  wire logic signed [15:0]   i_nv_sp,
    // Recipe control and step storage.
    input  wire logic                 i_rc_start,
    input  wire logic                 i_rc_stop,
    input  wire logic                 i_rc_single,
    input  wire logic        [2:0]    i_rc_last,
    input  wire logic                 i_step_we,
    input  wire logic        [2:0]    i_step_addr,
    input  wire step_t                i_step_data,
    // Results.
    output logic                      o_out1_on,
    output logic                      o_out2_on,
    output logic             [7:0]    o_pwr1,
    output logic             [7:0]    o_pwr2,
    output logic signed [15:0]        o_active_sp,
    output sp_src_t                   o_sp_src,
    output logic                      o_nv_we,
    output logic signed [15:0]        o_nv_wdata,
    output logic                      o_rc_running
);
    // Clamp a value into the configured setpoint range.
    function automatic logic signed [15:0] clamp(
        input logic signed [15:0] v,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    // On/off decision with hold between thresholds; signed 18-bit math.
    function automatic logic onoff_next(
        input logic               cur,
        input logic signed [15:0] pv,
        input logic signed [15:0] sp,
        input out_cfg_t           c);
        logic signed [17:0] eff, half, p;
        eff  = c.cooling ? (18'(sp) + 18'(c.dband))
                         : (18'(sp) - 18'(c.dband));
        half = 18'(c.hyst) >>> 1;
        p    = 18'(pv);
        onoff_next = cur;
        if (c.cooling)
        begin
            if (p >= eff + half)
                onoff_next = 1'b1;
            else if (p <= eff - half)
                onoff_next = 1'b0;
        end
        else
        begin
            if (p <= eff - half)
                onoff_next = 1'b1;
            else if (p >= eff + half)
                onoff_next = 1'b0;
        end
    endfunction
    // Volatile setpoint state.
    logic signed [15:0] sp_ram_q, sp_ram_d;
    logic signed [15:0] sp2_q, sp2_d;
    logic               loaded_q, loaded_d;
    logic               nv_we_q, nv_we_d;
    logic signed [15:0] nv_wd_q, nv_wd_d;
    // Host writes are clamped; the non-volatile copy only leaves as a
    // request, so wear is the host's concern, not this block's.
    always_comb
    begin
        sp_ram_d = sp_ram_q;
        sp2_d    = sp2_q;
        loaded_d = 1'b1;
        nv_we_d  = 1'b0;
        nv_wd_d  = nv_wd_q;
        if (!loaded_q)
        begin
            sp_ram_d = clamp(i_nv_sp, i_sp_lo, i_sp_hi);
        end
        else if (i_sp_wr.valid)
        begin
            if (i_sp_wr.to_ram)
                sp_ram_d = clamp(i_sp_wr.value, i_sp_lo, i_sp_hi);
            if (i_sp_wr.to_nv)
            begin
                nv_we_d = 1'b1;
                nv_wd_d = clamp(i_sp_wr.value, i_sp_lo, i_sp_hi);
            end
        end
        if (i_sp2_wr)
            sp2_d = clamp(i_sp2_val, i_sp_lo, i_sp_hi);
    end
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            sp_ram_q <= `SP_RST;
            sp2_q    <= `SP_RST;
            loaded_q <= 1'b0;
            nv_we_q  <= 1'b0;
            nv_wd_q  <= `SP_RST;
        end
        else if (i_ce)
        begin
            sp_ram_q <= sp_ram_d;
            sp2_q    <= sp2_d;
            loaded_q <= loaded_d;
            nv_we_q  <= nv_we_d;
            nv_wd_q  <= nv_wd_d;
        end
    end
    // Recipe engine.
    rc_state_t          rc_q, rc_d;
    logic        [2:0]  idx_q, idx_d;
    logic signed [15:0] rsp_q, rsp_d;
    logic        [15:0] cnt_q, cnt_d;
    logic               fetch_q, fetch_d;
    step_t              step;
    recipe_mem #(.DEPTH(STEPS), .AW(3)) u_mem
    (
        .i_clk   (i_clk),
        .i_ce    (i_ce),
        .i_we    (i_step_we),
        .i_waddr (i_step_addr),
        .i_wdata (i_step_data),
        .i_raddr (idx_d),
        .o_rdata (step)
    );
    // Ramp moves by rate per PV sample toward the clamped level, then soaks unless in single mode.
    always_comb
    begin
        logic signed [15:0] tgt;
        logic signed [16:0] diff;
        logic signed [16:0] rate;
        tgt     = clamp(step.level, i_sp_lo, i_sp_hi);
        diff    = 17'(tgt) - 17'(rsp_q);
        rate    = $signed({1'b0, step.rate}); // Keeps the landing test signed.
        rc_d    = rc_q;
        idx_d   = idx_q;
        rsp_d   = rsp_q;
        cnt_d   = cnt_q;
        fetch_d = 1'b0;
        case (rc_q)
            RC_IDLE:
            begin
                if (i_rc_start && loaded_q)
                begin
                    rc_d    = RC_RAMP;
                    idx_d   = 3'h0;
                    rsp_d   = sp_ram_q;
                    fetch_d = 1'b1;
                end
            end
            RC_RAMP:
            begin
                if (!fetch_q && i_pv_valid)
                begin
                    if (diff <= rate && -diff <= rate)
                    begin
                        rsp_d = tgt;
                        cnt_d = step.soak;
                        rc_d  = i_rc_single ? RC_IDLE : RC_SOAK;
                    end
                    else if (diff > 0)
                        rsp_d = 16'(rsp_q + $signed({1'b0, step.rate}));
                    else
                        rsp_d = 16'(rsp_q - $signed({1'b0, step.rate}));
                end
            end
            RC_SOAK:
            begin
                if (i_pv_valid)
                begin
                    if (cnt_q != 16'h0)
                        cnt_d = cnt_q - 16'h1;
                    else if (idx_q == i_rc_last)
                        rc_d = RC_IDLE;
                    else
                    begin
                        idx_d   = idx_q + 3'h1;
                        fetch_d = 1'b1;
                        rc_d    = RC_RAMP;
                    end
                end
            end
            default:
                rc_d = RC_IDLE;
        endcase
        if (i_rc_stop)
            rc_d = RC_IDLE;
    end
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            rc_q    <= RC_IDLE;
            idx_q   <= 3'h0;
            rsp_q   <= `SP_RST;
            cnt_q   <= 16'h0;
            fetch_q <= 1'b0;
        end
        else if (i_ce)
        begin
            rc_q    <= rc_d;
            idx_q   <= idx_d;
            rsp_q   <= rsp_d;
            cnt_q   <= cnt_d;
            fetch_q <= fetch_d;
        end
    end
    // Remote input scaled linearly: lo + raw*(hi-lo)/full scale.
    logic signed [16:0] span;
    logic signed [29:0] prod;
    logic signed [15:0] ras_val;
    assign span    = 17'(i_ras_hi) - 17'(i_ras_lo);
    assign prod    = 30'(span) * $signed({18'h0, i_ras_raw});
    assign ras_val = 16'(17'(i_ras_lo) + 17'(prod >>> RAW_W));
    // Priority source selection.
    sp_src_t            src;
    logic signed [15:0] act_sp;
    always_comb
    begin
        if (rc_q != RC_IDLE)
        begin
            src    = SRC_RECIPE;
            act_sp = rsp_q;
        end
        else if (i_ras_contact)
        begin
            src    = SRC_REMOTE;
            act_sp = ras_val;
        end
        else if (i_sp2_contact)
        begin
            src    = SRC_SECOND;
            act_sp = sp2_q;
        end
        else
        begin
            src    = SRC_LOCAL;
            act_sp = sp_ram_q;
        end
    end
    // Output decisions, evaluated only when a new sample arrives; active setpoint and source register every cycle.
    logic               on1_q, on1_d, on2_q, on2_d;
    logic signed [15:0] sp_q, sp_d;
    sp_src_t            src_q, src_d;
    logic signed [15:0] prev_q, prev_d;
    logic signed [23:0] integ_q, integ_d;
    logic        [7:0]  pw1_q, pw1_d, pw2_q, pw2_d;
    // PID power shared by both PID outputs; output 2 acts direct.
    always_comb
    begin
        logic signed [17:0] err;
        logic signed [35:0] u;
        u       = 36'sh0;
        err     = 18'(act_sp) - 18'(i_pv);
        on1_d   = on1_q;
        on2_d   = on2_q;
        sp_d    = act_sp;
        src_d   = src;
        prev_d  = prev_q;
        integ_d = integ_q;
        pw1_d   = pw1_q;
        pw2_d   = pw2_q;
        if (i_pv_valid && loaded_q)
        begin
            on1_d   = (i_cfg1.otype == OUT_ONOFF) &&
                      onoff_next(on1_q, i_pv, act_sp, i_cfg1);
            on2_d   = (i_cfg2.otype == OUT_ONOFF) &&
                      onoff_next(on2_q, i_pv, act_sp, i_cfg2);
            integ_d = 24'(integ_q + 24'(err));
            prev_d  = i_pv;
            u = 36'(err) * $signed({1'b0, i_kp})
              + 36'(integ_d) * $signed({1'b0, i_ki})
              - 36'(18'(i_pv) - 18'(prev_q)) * $signed({1'b0, i_kd});
            pw1_d = (u <= 0) ? 8'h0 : ((u >= 36'sd100) ? 8'h64 : 8'(u));
            pw2_d = (u >= 0) ? 8'h0 : ((u <= -36'sd100) ? 8'h64 : 8'(-u));
            if (i_cfg1.otype != OUT_PID)
                pw1_d = 8'h0;
            if (i_cfg2.otype != OUT_PID)
                pw2_d = 8'h0;
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            on1_q   <= 1'b0;
            on2_q   <= 1'b0;
            sp_q    <= `SP_RST;
            src_q   <= SRC_LOCAL;
            prev_q  <= `SP_RST;
            integ_q <= 24'sh0;
            pw1_q   <= 8'h0;
            pw2_q   <= 8'h0;
        end
        else if (i_ce)
        begin
            on1_q   <= on1_d;
            on2_q   <= on2_d;
            sp_q    <= sp_d;
            src_q   <= src_d;
            prev_q  <= prev_d;
            integ_q <= integ_d;
            pw1_q   <= pw1_d;
            pw2_q   <= pw2_d;
        end
    end
    // Registered results; on/off outputs carry a single bit only.
    assign o_out1_on    = on1_q;
    assign o_out2_on    = on2_q;
    assign o_pwr1       = pw1_q;
    assign o_pwr2       = pw2_q;
    assign o_active_sp  = sp_q;
    assign o_sp_src     = src_q;
    assign o_nv_we      = nv_we_q;
    assign o_nv_wdata   = nv_wd_q;
    assign o_rc_running = (rc_q != RC_IDLE);
endmodule

// file: include/onoff_params.svh
`ifndef ONOFF_PARAMS_SVH
`define ONOFF_PARAMS_SVH
// Width of process values, setpoints, hysteresis and deadband (signed).
`define PV_W          16
// Width of the raw remote analog input sample (unsigned).
`define RAS_RAW_W     12
// Number of recipe steps held by the ramp/soak engine.
`define RECIPE_STEPS  8
// Step index width.
`define STEP_W        3
// Reset value of the volatile setpoint before the stored copy is loaded.
`define SP_RST        16'sh0000
// Output type encodings.
`define OTYPE_PID     1'b0
`define OTYPE_ONOFF   1'b1
`endif

// file: include/onoff_pkg.sv
package onoff_pkg;
    // Control law chosen for one output.
    typedef enum logic [0:0]
    {
        OUT_PID   = 1'b0,
        OUT_ONOFF = 1'b1
    } out_type_t;

    // Which source drives the active setpoint.
    typedef enum logic [1:0]
    {
        SRC_LOCAL  = 2'b00,
        SRC_SECOND = 2'b01,
        SRC_REMOTE = 2'b10,
        SRC_RECIPE = 2'b11
    } sp_src_t;

    // Recipe engine states.
    typedef enum logic [1:0]
    {
        RC_IDLE = 2'b00,
        RC_RAMP = 2'b01,
        RC_SOAK = 2'b10
    } rc_state_t;

    // Per-output on/off tuning.
    typedef struct packed
    {
        logic signed [15:0] hyst;
        logic signed [15:0] dband;
        logic               cooling;
        out_type_t          otype;
    } out_cfg_t;

    // One recipe step: target level, ramp rate per sample, soak samples.
    typedef struct packed
    {
        logic signed [15:0] level;
        logic        [15:0] rate;
        logic        [15:0] soak;
    } step_t;

    // Host setpoint write request.
    typedef struct packed
    {
        logic               valid;
        logic               to_ram;
        logic               to_nv;
        logic signed [15:0] value;
    } sp_write_t;
endpackage

// file: logic/recipe_mem.sv
`timescale 1ns/1ns
`include "onoff_params.svh"
// Step storage for the ramp/soak engine; read data are registered.
module recipe_mem
    import onoff_pkg::*;
#(
    parameter int DEPTH = `RECIPE_STEPS,
    parameter int AW    = `STEP_W
)
(
    // Clock and enable.
    input  wire logic          i_clk,
    input  wire logic          i_ce,
    // Write port.
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire step_t         i_wdata,
    // Read port.
    input  wire logic [AW-1:0] i_raddr,
    output step_t              o_rdata
);
    step_t mem_q [DEPTH];
    step_t rdata_q;

    // Write and registered read; storage needs no reset.
    always_ff @(posedge i_clk)
    begin
        if (i_ce)
        begin
            if (i_we)
            begin
                mem_q[i_waddr] <= i_wdata;
            end
            rdata_q <= mem_q[i_raddr];
        end
    end

    assign o_rdata = rdata_q;
endmodule

// file: testbench/onoff_chk.sv
`timescale 1ns/1ns
// Port-level watch on source choice, output mode and host writes.
module onoff_chk
    import onoff_pkg::*;
(
    // Clock, reset, enable.
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic       i_ce,
    // Requests.
    input wire logic       i_pv_valid,
    input wire out_cfg_t   i_cfg1,
    input wire sp_write_t  i_sp_wr,
    input wire logic       i_ras_contact,
    input wire logic       i_sp2_contact,
    input wire logic       i_rc_start,
    input wire logic       i_rc_stop,
    // Results.
    input wire logic       o_out1_on,
    input wire logic [7:0] o_pwr1,
    input wire sp_src_t    o_sp_src,
    input wire logic       o_nv_we,
    input wire logic       o_rc_running
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // Samples that coincide with recipe start or stop are left out.
    logic smp;
    assign smp = i_ce && i_pv_valid && !i_rc_start && !i_rc_stop;

    nv_write_a: assert property (
        i_ce && i_sp_wr.valid && i_sp_wr.to_nv && $past(i_rst_b) |=> o_nv_we)
        else $error("stored write not requested");
    nv_cause_a: assert property (
        o_nv_we |-> $past(i_sp_wr.valid && i_sp_wr.to_nv))
        else $error("stored write without cause");
    pid_flag_a: assert property (
        $past(i_ce && i_pv_valid && i_cfg1.otype == OUT_PID) |-> !o_out1_on)
        else $error("pid output shows on state");
    onoff_pwr_a: assert property (
        $past(i_ce && i_pv_valid && i_cfg1.otype == OUT_ONOFF)
        |-> o_pwr1 == 8'h00)
        else $error("on/off output shows power");
    recipe_src_a: assert property (
        smp && o_rc_running |=> o_sp_src == SRC_RECIPE)
        else $error("recipe not chosen");
    remote_src_a: assert property (
        smp && !o_rc_running && i_ras_contact |=> o_sp_src == SRC_REMOTE)
        else $error("remote not chosen");
    second_src_a: assert property (
        smp && !o_rc_running && !i_ras_contact && i_sp2_contact
        |=> o_sp_src == SRC_SECOND)
        else $error("second not chosen");
    local_src_a: assert property (
        smp && !o_rc_running && !i_ras_contact && !i_sp2_contact
        |=> o_sp_src == SRC_LOCAL)
        else $error("local not chosen");
    rc_start_a: assert property (
        i_ce && i_rc_start && !i_rc_stop && !o_rc_running && $past(i_rst_b)
        |=> o_rc_running)
        else $error("recipe did not start");
    rc_stop_a: assert property (
        i_ce && i_rc_stop |=> !o_rc_running)
        else $error("recipe did not stop");
    out_hold_a: assert property (
        !(i_ce && i_pv_valid) && $past(i_rst_b) |=> $stable(o_out1_on))
        else $error("output moved without sample");
endmodule

// file: testbench/pv_sensor_model.sv
`timescale 1ns/1ns
// Process sensor: one valid pulse for each requested sample.
module pv_sensor_model
(
    // Clock and request.
    input  wire logic               i_clk,
    input  wire logic               i_req,
    input  wire logic signed [15:0] i_value,
    // Sample towards the controller.
    output logic                    o_pv_valid,
    output logic signed [15:0]      o_pv
);
    // Outside the pulse the word is inverted, so a stale value never passes.
    initial
    begin
        o_pv_valid = 1'b0;
        o_pv       = 16'sh0000;
    end
    always @(posedge i_clk)
    begin
        o_pv_valid <= i_req;
        o_pv       <= i_req ? i_value : ~o_pv;
    end
endmodule

// file: testbench/onoff_control_setpoint_select_tb.sv
`timescale 1ns/1ns
module onoff_control_setpoint_select_tb
    import onoff_pkg::*;
;
    logic i_clk, i_rst_b, i_ce, i_pv_valid, req, i_ras_contact, i_sp2_contact;
    logic i_sp2_wr, i_rc_start, i_rc_stop, i_rc_single, i_step_we;
    logic o_out1_on, o_out2_on, o_nv_we, o_rc_running;
    logic signed [15:0] i_pv, pv_req, i_sp_lo, i_sp_hi, i_ras_lo, i_ras_hi;
    logic signed [15:0] i_sp2_val, i_nv_sp, o_active_sp, o_nv_wdata;
    logic [7:0]  i_kp, i_ki, i_kd, o_pwr1, o_pwr2;
    logic [11:0] i_ras_raw;
    logic [2:0]  i_rc_last, i_step_addr;
    out_cfg_t    i_cfg1, i_cfg2;
    sp_write_t   i_sp_wr;
    step_t       i_step_data;
    sp_src_t     o_sp_src;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          pvs[12] = '{70, 95, 115, 106, 105, 86, 85, 104, 105, 96,
                             95, 85};
    logic [0:11] hx = 12'b1000_0011_0011;
    logic [0:11] cx = 12'b0011_0001_1110;

    onoff_control_setpoint_select dut (.i_clk, .i_rst_b, .i_ce, .i_pv,
        .i_pv_valid, .i_cfg1, .i_cfg2, .i_kp, .i_ki, .i_kd, .i_sp_lo,
        .i_sp_hi, .i_ras_lo, .i_ras_hi, .i_ras_raw, .i_ras_contact,
        .i_sp2_contact, .i_sp_wr, .i_sp2_wr, .i_sp2_val, .i_nv_sp,
        .i_rc_start, .i_rc_stop, .i_rc_single, .i_rc_last, .i_step_we,
        .i_step_addr, .i_step_data, .o_out1_on, .o_out2_on, .o_pwr1,
        .o_pwr2, .o_active_sp, .o_sp_src, .o_nv_we, .o_nv_wdata,
        .o_rc_running);
    pv_sensor_model sensor (.i_clk, .i_req(req), .i_value(pv_req),
        .o_pv_valid(i_pv_valid), .o_pv(i_pv));

    // Free-running 250 MHz clock.
    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Results of a sample are settled one edge after the sensor pulse.
    task automatic sample(input int v);
        @(posedge i_clk) #1;
        req = 1'b1;
        pv_req = 16'(v);
        @(posedge i_clk) #1;
        req = 1'b0;
        @(posedge i_clk) #1;
    endtask

    task automatic write_sp(input int v, input logic ram, input logic nv);
        @(posedge i_clk) #1;
        i_sp_wr = '{1'b1, ram, nv, 16'(v)};
        @(posedge i_clk) #1;
        i_sp_wr = '0;
    endtask

    task automatic t_power_up;
        sample(0);
        check(o_active_sp, 16'h0078);
        check(o_sp_src, SRC_LOCAL);
    endtask

    // Limits clamp writes; only the RAM copy steers control.
    task automatic t_host;
        write_sp(900, 1'b1, 1'b1);
        check(o_nv_we, 1'b1);
        check(o_nv_wdata, 16'h0190);
        @(posedge i_clk) #1;
        check(o_nv_we, 1'b0);
        write_sp(50, 1'b1, 1'b0);
        check(o_nv_we, 1'b0);
        write_sp(-7, 1'b0, 1'b1);
        check(o_nv_wdata, 16'h0000);
        sample(0);
        check(o_active_sp, 16'h0032);
    endtask

    // Heating and cooling windows; from row 7 new deadbands apply.
    task automatic t_onoff;
        write_sp(100, 1'b1, 1'b0);
        for (int i = 0; i < 12; i++)
        begin
            if (i == 7)
            begin
                i_cfg1.dband = 16'sh0000;
                i_cfg2.dband = -16'sd10;
            end
            sample(pvs[i]);
            check(o_out1_on, hx[i]);
            check(o_out2_on, cx[i]);
        end
    endtask

    task automatic t_pid;
        i_cfg1.otype = OUT_PID;
        sample(0);
        check(o_out1_on, 1'b0);
        check(o_pwr1, 8'h64);
        check(o_pwr2, 8'h00);
        sample(40);
        check(o_pwr1, 8'h3c);
        i_cfg1.otype = OUT_ONOFF;
    endtask

    // Walk the priority chain upward, then back down.
    task automatic t_sources;
        @(posedge i_clk) #1;
        i_sp2_wr = 1'b1;
        i_sp2_val = 16'sd999;
        i_sp2_contact = 1'b1;
        @(posedge i_clk) #1;
        i_sp2_wr = 1'b0;
        sample(0);
        check(o_sp_src, SRC_SECOND);
        check(o_active_sp, 16'h0190);
        i_ras_contact = 1'b1;
        sample(0);
        check(o_sp_src, SRC_REMOTE);
        check(o_active_sp, 16'h01f4);
        i_ras_raw = 12'hfff;
        sample(0);
        check(o_active_sp, 16'h03e7);
        i_step_we = 1'b1;
        i_step_data = '{16'sd300, 16'h0096, 16'h0000};
        @(posedge i_clk) #1;
        i_step_we = 1'b0;
        i_rc_start = 1'b1;
        @(posedge i_clk) #1;
        i_rc_start = 1'b0;
        check(o_rc_running, 1'b1);
        sample(0);
        check(o_sp_src, SRC_RECIPE);
        sample(0);
        check(o_active_sp, 16'h00fa);
        check(o_rc_running, 1'b0);
        i_rc_start = 1'b1;
        @(posedge i_clk) #1;
        i_rc_start = 1'b0;
        check(o_rc_running, 1'b1);
        i_rc_stop = 1'b1;
        @(posedge i_clk) #1;
        i_rc_stop = 1'b0;
        check(o_rc_running, 1'b0);
        i_ras_contact = 1'b0;
        i_sp2_contact = 1'b0;
        sample(0);
        check(o_sp_src, SRC_LOCAL);
    endtask

    // Main sequence; inputs settle before the first edge.
    initial
    begin
        {i_rst_b, req, i_ras_contact, i_sp2_contact, i_sp2_wr} = '0;
        {i_rc_start, i_rc_stop, i_step_we, i_rc_last, i_step_addr} = '0;
        i_ce = 1'b1;
        i_rc_single = 1'b1;
        pv_req = 16'sh0000;
        i_sp_lo = 16'sh0000;
        i_sp_hi = 16'sd400;
        i_ras_lo = 16'sh0000;
        i_ras_hi = 16'sd1000;
        i_ras_raw = 12'h800;
        i_sp2_val = 16'sh0000;
        i_nv_sp = 16'sd120;
        {i_kp, i_ki, i_kd} = {8'h01, 8'h00, 8'h00};
        i_cfg1 = '{16'sd10, 16'sd10, 1'b0, OUT_ONOFF};
        i_cfg2 = '{16'sd10, 16'sd10, 1'b1, OUT_ONOFF};
        i_sp_wr = '0;
        i_step_data = '0;
        repeat (8) @(posedge i_clk);
        #1 i_rst_b = 1'b1;
        @(posedge i_clk);
        t_power_up();
        t_host();
        t_onoff();
        t_pid();
        t_sources();
        finish_test();
    end

    // A hang is cut short well past the expected 90 or so cycles.
    initial
    begin
        #20000;
        n_mismatch++;
        finish_test();
    end
endmodule

bind onoff_control_setpoint_select onoff_chk chk (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_ce(i_ce), .i_pv_valid(i_pv_valid),
    .i_cfg1(i_cfg1), .i_sp_wr(i_sp_wr), .i_ras_contact(i_ras_contact),
    .i_sp2_contact(i_sp2_contact), .i_rc_start(i_rc_start),
    .i_rc_stop(i_rc_stop), .o_out1_on(o_out1_on), .o_pwr1(o_pwr1),
    .o_sp_src(o_sp_src), .o_nv_we(o_nv_we), .o_rc_running(o_rc_running));
